// [design/slvt_consts.vh]
// Purpose: constants for the address and vlan lookup tables
// Assumes: 32-bit register port, byte addresses, one word per register
// Notes: entry and register field positions are given as bit ranges or single bit indexes
`ifndef SLVT_CONSTS_VH
`define SLVT_CONSTS_VH
// --------------------------------------------------------------
// sizes
// --------------------------------------------------------------
`define SLVT_NPORTS 11
`define SLVT_CPU_PORT 4'hB
`define SLVT_LAST_PORT 4'hA
`define SLVT_AT_LAST 4'hF
`define SLVT_VT_LAST 12'hFFF
// --------------------------------------------------------------
// address entry layout
// --------------------------------------------------------------
`define SLVT_E_VALID 75
`define SLVT_E_AGED 74
`define SLVT_E_LOCK 73
`define SLVT_E_KIND 72:71
`define SLVT_E_KIND_HI 72
`define SLVT_E_PORT 70:67
`define SLVT_E_DIDX 66:61
`define SLVT_E_KEY 60:48
`define SLVT_E_VID 59:48
`define SLVT_E_KEYX 60
`define SLVT_E_MAC 47:0
`define SLVT_E_V6PORTS 42:32
`define SLVT_E_V6LOW 31:0
`define SLVT_KIND_IPV6 2'h3
`define SLVT_IPV6_PREFIX 16'h3333
// --------------------------------------------------------------
// commands
// --------------------------------------------------------------
`define SLVT_AT_IDLE 3'h0
`define SLVT_AT_LEARN 3'h1
`define SLVT_AT_FORGET 3'h2
`define SLVT_AT_AGE 3'h3
`define SLVT_AT_READ 3'h4
`define SLVT_AT_INIT 3'h6
`define SLVT_AT_NEXT 3'h7
`define SLVT_VT_IDLE 2'h0
`define SLVT_VT_INIT 2'h1
`define SLVT_VT_READ 2'h2
`define SLVT_VT_WRITE 2'h3
// --------------------------------------------------------------
// register offsets
// --------------------------------------------------------------
`define SLVT_REG_AT_CMD 8'h00
`define SLVT_REG_AT_MACLO 8'h04
`define SLVT_REG_AT_MACHI 8'h08
`define SLVT_REG_AT_INDEX 8'h0C
`define SLVT_REG_FILTER 8'h10
`define SLVT_REG_KEYCFG 8'h14
`define SLVT_REG_VT_INDEX 8'h18
`define SLVT_REG_VT_CMD 8'h1C
`define SLVT_REG_REFUSED 8'h20
`define SLVT_REG_LIMIT0 8'h40
// --------------------------------------------------------------
// register fields and reset values
// --------------------------------------------------------------
`define SLVT_C_CMD 2:0
`define SLVT_C_KIND 4:3
`define SLVT_C_LOCK 5
`define SLVT_C_VALID 6
`define SLVT_C_PORT 10:7
`define SLVT_C_DIDX 16:11
`define SLVT_H_KEY 28:16
`define SLVT_F_PORT 3:0
`define SLVT_F_PORT_EN 4
`define SLVT_F_VID 16:5
`define SLVT_F_VID_EN 17
`define SLVT_F_DOM 18
`define SLVT_F_DOM_EN 19
`define SLVT_V_VID 11:0
`define SLVT_V_FLAGS 15:12
`define SLVT_A_CMD 1:0
`define SLVT_A_PORTS 12:2
`define SLVT_KEYMASK_RST 12'h000
`define SLVT_LIMIT_RST 5'h10
`define SLVT_VT_INIT_ENTRY 15'h07FF
`endif

// [design/slvt_top.v]
// Purpose: address table and vlan table lookup logic of a layer-2 analyzer
// Assumes: frame requests synchronous to clk; software waits for idle commands
// Notes: address table is a small fully associative store of 16 entries
`timescale 1ns/1ps
`include "slvt_consts.vh"

module slvt_top (
  input wire clk,
  input wire rst,
  input wire [7:0] addr,
  input wire [31:0] wdata,
  input wire wr,
  input wire rd,
  output reg [31:0] rdata,
  input wire fr_valid,
  input wire [3:0] fr_port,
  input wire [11:0] fr_vid,
  input wire [47:0] fr_dmac,
  input wire [47:0] fr_smac,
  input wire fr_ipv6,
  input wire [1:0] fr_key_sel,
  input wire [11:0] fr_key_val,
  input wire fr_key_ext,
  output reg res_valid,
  output reg res_hit,
  output reg res_ipv6_hit,
  output reg [10:0] res_ports,
  output reg [5:0] res_group_idx,
  output reg [11:0] res_vlan_ports,
  output reg res_ingress_drop,
  output reg res_mirror,
  output reg res_private,
  output reg res_learn_off,
  output reg res_limit_copy,
  output reg res_limit_discard,
  output reg res_refused
);
  // --------------------------------------------------------------
  // storage and registers
  // --------------------------------------------------------------
  localparam ST_IDLE = 1'b0;
  localparam ST_SWEEP = 1'b1;
  reg [75:0] at_mem [0:15];
  reg [14:0] vt_mem [0:4095];
  reg [16:0] at_ctl;
  reg [31:0] at_maclo;
  reg [28:0] at_machi;
  reg [3:0] at_idx;
  reg [19:0] flt;
  reg [11:0] kmask;
  reg [15:0] vt_idx;
  reg [12:0] vt_acc;
  reg [31:0] refused;
  reg at_st;
  reg [3:0] sw_idx;
  reg [11:0] vt_ptr;
  reg gn_found;
  reg [59:0] gn_best;
  reg [3:0] gn_bidx;
  wire [4:0] cnt [0:10];
  wire [4:0] lim [0:10];
  wire [10:0] cpcfg;
  wire [10:0] dccfg;
  wire [2:0] at_cmd = at_ctl[`SLVT_C_CMD];
  wire [1:0] vt_cmd = vt_acc[`SLVT_A_CMD];

  // --------------------------------------------------------------
  // lookup keys
  // --------------------------------------------------------------
  wire [12:0] mkey = {1'b0, fr_vid & ~kmask};
  wire [12:0] dkey = fr_key_sel[0] ? {fr_key_ext, fr_key_val} : mkey;
  wire [12:0] skey = fr_key_sel[1] ? {fr_key_ext, fr_key_val} : mkey;
  wire [12:0] c_key = at_machi[`SLVT_H_KEY];
  wire [47:0] c_mac = {at_machi[15:0], at_maclo};
  wire [59:0] gn_start = {c_key[11:0], c_mac};

  // --------------------------------------------------------------
  // per entry match
  // --------------------------------------------------------------
  wire [15:0] d_hit;
  wire [15:0] s_hit;
  wire [15:0] c_hit;
  wire [15:0] f_ok;
  wire [15:0] free;
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi = gi + 1) begin : g_ent
      wire [75:0] e = at_mem[gi];
      wire v6 = e[`SLVT_E_KIND] == `SLVT_KIND_IPV6;
      wire v6_hit = fr_ipv6 && fr_dmac[47:32] == `SLVT_IPV6_PREFIX &&
                    e[`SLVT_E_V6LOW] == fr_dmac[31:0];
      assign d_hit[gi] = e[`SLVT_E_VALID] && e[`SLVT_E_KEY] == dkey &&
                         (v6 ? v6_hit : e[`SLVT_E_MAC] == fr_dmac);
      assign s_hit[gi] = e[`SLVT_E_VALID] && !e[`SLVT_E_KIND_HI] &&
                         e[`SLVT_E_KEY] == skey && e[`SLVT_E_MAC] == fr_smac;
      assign c_hit[gi] = e[`SLVT_E_VALID] && e[`SLVT_E_KEY] == c_key &&
                         e[`SLVT_E_MAC] == c_mac;
      // all enabled conditions must hold
      assign f_ok[gi] = (!flt[`SLVT_F_PORT_EN] || e[`SLVT_E_PORT] == flt[`SLVT_F_PORT]) &&
                        (!flt[`SLVT_F_VID_EN] || e[`SLVT_E_VID] == flt[`SLVT_F_VID]) &&
                        (!flt[`SLVT_F_DOM_EN] || e[`SLVT_E_KEYX] == flt[`SLVT_F_DOM]);
      assign free[gi] = !e[`SLVT_E_VALID];
    end
  endgenerate

  reg [3:0] d_idx;
  reg [3:0] s_idx;
  reg [3:0] c_idx;
  reg [3:0] f_idx;
  integer j;
  always @* begin
    d_idx = 4'h0;
    s_idx = 4'h0;
    c_idx = 4'h0;
    f_idx = 4'h0;
    for (j = 15; j >= 0; j = j - 1) begin
      if (d_hit[j]) d_idx = j[3:0];
      if (s_hit[j]) s_idx = j[3:0];
      if (c_hit[j]) c_idx = j[3:0];
      if (free[j]) f_idx = j[3:0];
    end
  end

  // --------------------------------------------------------------
  // limits and vlan view of the frame
  // --------------------------------------------------------------
  wire [10:0] full_v;
  wire fr_front = fr_port <= `SLVT_LAST_PORT;
  wire [75:0] de = at_mem[d_idx];
  wire [75:0] se = at_mem[s_idx];
  wire [75:0] ce = at_mem[c_idx];
  wire [75:0] we_e = at_mem[sw_idx];
  wire [14:0] ve = vt_mem[fr_vid];
  wire fr_member = !fr_front || ve[fr_port];
  wire fr_full = fr_front && full_v[fr_port];
  wire [3:0] cp_port = at_ctl[`SLVT_C_PORT];
  wire cp_full = cp_port <= `SLVT_LAST_PORT && full_v[cp_port];
  wire [59:0] sw_key = {we_e[`SLVT_E_VID], we_e[`SLVT_E_MAC]};
  wire gn_take = we_e[`SLVT_E_VALID] && f_ok[sw_idx] && sw_key > gn_start &&
                 (!gn_found || sw_key < gn_best);
  wire [75:0] gn_e = gn_take ? we_e : at_mem[gn_bidx];
  wire gn_ok = gn_take || gn_found;

  // --------------------------------------------------------------
  // table update decision
  // --------------------------------------------------------------
  reg we;
  reg [3:0] widx;
  reg [75:0] went;
  reg inc_en;
  reg [3:0] inc_p;
  reg dec_en;
  reg [3:0] dec_p;
  reg ref_ev;
  reg over_ev;
  reg [75:0] nent;
  reg new_cnt;
  reg old_cnt;
  always @* begin
    we = 1'b0;
    widx = 4'h0;
    went = 76'h0;
    inc_en = 1'b0;
    inc_p = 4'h0;
    dec_en = 1'b0;
    dec_p = 4'h0;
    ref_ev = 1'b0;
    over_ev = 1'b0;
    nent = {1'b1, 1'b0, at_ctl[`SLVT_C_LOCK], at_ctl[`SLVT_C_KIND], cp_port,
            at_ctl[`SLVT_C_DIDX], c_key, c_mac};
    // counted means unlocked and neither ip multicast kind
    new_cnt = !at_ctl[`SLVT_C_LOCK] && !at_ctl[4];
    old_cnt = !ce[`SLVT_E_LOCK] && !ce[`SLVT_E_KIND_HI];
    if (at_st == ST_SWEEP) begin
      if (at_cmd == `SLVT_AT_INIT) begin
        we = 1'b1;
        widx = sw_idx;
      end else if (at_cmd == `SLVT_AT_AGE && we_e[`SLVT_E_VALID] &&
                   !we_e[`SLVT_E_LOCK] && f_ok[sw_idx]) begin
        we = 1'b1;
        widx = sw_idx;
        went = we_e;
        went[`SLVT_E_AGED] = 1'b1;
        if (we_e[`SLVT_E_AGED]) begin
          went[`SLVT_E_VALID] = 1'b0;
          dec_en = !we_e[`SLVT_E_KIND_HI];
          dec_p = we_e[`SLVT_E_PORT];
        end
      end
    end else if (at_cmd == `SLVT_AT_LEARN) begin
      if (new_cnt && cp_full && !(|c_hit && old_cnt && ce[`SLVT_E_PORT] == cp_port)) begin
        ref_ev = 1'b1;
        if (|c_hit) begin
          we = 1'b1;
          widx = c_idx;
          dec_en = old_cnt;
          dec_p = ce[`SLVT_E_PORT];
        end
      end else if (|c_hit || |free) begin
        we = 1'b1;
        widx = |c_hit ? c_idx : f_idx;
        went = nent;
        dec_en = |c_hit && old_cnt;
        dec_p = ce[`SLVT_E_PORT];
        inc_en = new_cnt;
        inc_p = cp_port;
      end
    end else if (at_cmd == `SLVT_AT_FORGET) begin
      if (|c_hit) begin
        we = 1'b1;
        widx = c_idx;
        dec_en = old_cnt;
        dec_p = ce[`SLVT_E_PORT];
      end
    end else if (at_cmd == `SLVT_AT_IDLE && fr_valid && fr_front && !ve[13]) begin
      if (|s_hit && se[`SLVT_E_PORT] == fr_port) begin
        we = 1'b1;
        widx = s_idx;
        went = se;
        went[`SLVT_E_AGED] = 1'b0;
      end else if (|s_hit && !se[`SLVT_E_LOCK]) begin
        we = 1'b1;
        widx = s_idx;
        dec_en = 1'b1;
        dec_p = se[`SLVT_E_PORT];
        if (fr_full) begin
          ref_ev = 1'b1;
          over_ev = 1'b1;
        end else begin
          went = se;
          went[`SLVT_E_AGED] = 1'b0;
          went[`SLVT_E_PORT] = fr_port;
          inc_en = 1'b1;
          inc_p = fr_port;
        end
      end else if (!(|s_hit)) begin
        if (fr_full) begin
          ref_ev = 1'b1;
          over_ev = 1'b1;
        end else if (|free) begin
          we = 1'b1;
          widx = f_idx;
          went = {1'b1, 1'b0, 1'b0, 2'h0, fr_port, 2'h0, fr_port, skey, fr_smac};
          inc_en = 1'b1;
          inc_p = fr_port;
        end
      end
    end
  end

  // --------------------------------------------------------------
  // per port limit, count and over limit actions
  // --------------------------------------------------------------
  wire cnt_clr = at_st == ST_IDLE && at_cmd == `SLVT_AT_INIT;
  genvar gp;
  generate
    for (gp = 0; gp < 11; gp = gp + 1) begin : g_port
      localparam [3:0] PN = gp;
      localparam [7:0] PA = {2'h0, PN, 2'h0} + `SLVT_REG_LIMIT0;
      wire up = inc_en && inc_p == PN;
      wire dn = dec_en && dec_p == PN;
      // per port state lives here so each slot has a single driver
      reg [4:0] c;
      reg [4:0] l;
      reg cp;
      reg dc;
      assign cnt[gp] = c;
      assign lim[gp] = l;
      assign cpcfg[gp] = cp;
      assign dccfg[gp] = dc;
      assign full_v[gp] = c >= l;
      always @(posedge clk or posedge rst) begin
        if (rst) begin
          c <= 5'h00;
          l <= `SLVT_LIMIT_RST;
          cp <= 1'b0;
          dc <= 1'b0;
        end else begin
          if (cnt_clr)
            c <= 5'h00;
          else
            c <= c + {4'h0, up} - {4'h0, dn};
          if (wr && addr == PA) begin
            l <= wdata[4:0];
            cp <= wdata[16];
            dc <= wdata[17];
          end
        end
      end
    end
  endgenerate

  // --------------------------------------------------------------
  // vlan table storage
  // --------------------------------------------------------------
  // no reset on the 4096 entries; the reset-time init sweep fills them
  always @(posedge clk) begin
    if (vt_cmd == `SLVT_VT_INIT)
      vt_mem[vt_ptr] <= `SLVT_VT_INIT_ENTRY;
    else if (vt_cmd == `SLVT_VT_WRITE)
      vt_mem[vt_idx[`SLVT_V_VID]] <= {vt_idx[`SLVT_V_FLAGS], vt_acc[`SLVT_A_PORTS]};
  end

  // --------------------------------------------------------------
  // address table storage, commands and frame results
  // --------------------------------------------------------------
  integer k;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      for (k = 0; k < 16; k = k + 1)
        at_mem[k] <= 76'h0;
      at_ctl <= 17'h00000;
      at_maclo <= 32'h00000000;
      at_machi <= 29'h00000000;
      at_idx <= 4'h0;
      flt <= 20'h00000;
      kmask <= `SLVT_KEYMASK_RST;
      vt_idx <= 16'h0000;
      vt_acc <= {11'h000, `SLVT_VT_INIT};
      refused <= 32'h00000000;
      at_st <= ST_IDLE;
      sw_idx <= 4'h0;
      vt_ptr <= 12'h000;
      gn_found <= 1'b0;
      gn_best <= 60'h0;
      gn_bidx <= 4'h0;
      res_valid <= 1'b0;
      res_hit <= 1'b0;
      res_ipv6_hit <= 1'b0;
      res_ports <= 11'h000;
      res_group_idx <= 6'h00;
      res_vlan_ports <= 12'h000;
      res_ingress_drop <= 1'b0;
      res_mirror <= 1'b0;
      res_private <= 1'b0;
      res_learn_off <= 1'b0;
      res_limit_copy <= 1'b0;
      res_limit_discard <= 1'b0;
      res_refused <= 1'b0;
    end else begin
      if (we)
        at_mem[widx] <= went;
      if (ref_ev)
        refused <= refused + 32'h00000001;
      if (wr) begin
        case (addr)
          `SLVT_REG_AT_CMD: at_ctl <= wdata[16:0];
          `SLVT_REG_AT_MACLO: at_maclo <= wdata;
          `SLVT_REG_AT_MACHI: at_machi <= wdata[28:0];
          `SLVT_REG_AT_INDEX: at_idx <= wdata[3:0];
          `SLVT_REG_FILTER: flt <= wdata[19:0];
          `SLVT_REG_KEYCFG: kmask <= wdata[11:0];
          `SLVT_REG_VT_INDEX: vt_idx <= wdata[15:0];
          `SLVT_REG_VT_CMD: vt_acc <= wdata[12:0];
          default: ;
        endcase
      end
      case (at_st)
        ST_IDLE: begin
          case (at_cmd)
            `SLVT_AT_LEARN, `SLVT_AT_FORGET: at_ctl[`SLVT_C_CMD] <= `SLVT_AT_IDLE;
            `SLVT_AT_READ: begin
              at_ctl <= {at_mem[at_idx][`SLVT_E_DIDX], at_mem[at_idx][`SLVT_E_PORT],
                         at_mem[at_idx][`SLVT_E_VALID], at_mem[at_idx][`SLVT_E_LOCK],
                         at_mem[at_idx][`SLVT_E_KIND], `SLVT_AT_IDLE};
              at_maclo <= at_mem[at_idx][31:0];
              at_machi <= {at_mem[at_idx][`SLVT_E_KEY], at_mem[at_idx][47:32]};
            end
            `SLVT_AT_AGE, `SLVT_AT_INIT, `SLVT_AT_NEXT: begin
              at_st <= ST_SWEEP;
              sw_idx <= 4'h0;
              gn_found <= 1'b0;
            end
            default: ;
          endcase
        end
        ST_SWEEP: begin
          sw_idx <= sw_idx + 4'h1;
          if (gn_take) begin
            gn_found <= 1'b1;
            gn_best <= sw_key;
            gn_bidx <= sw_idx;
          end
          if (sw_idx == `SLVT_AT_LAST) begin
            at_st <= ST_IDLE;
            at_ctl[`SLVT_C_CMD] <= `SLVT_AT_IDLE;
            if (at_cmd == `SLVT_AT_NEXT) begin
              at_ctl <= {gn_e[`SLVT_E_DIDX], gn_e[`SLVT_E_PORT], gn_ok,
                         gn_e[`SLVT_E_LOCK], gn_e[`SLVT_E_KIND], `SLVT_AT_IDLE};
              if (gn_ok) begin
                at_maclo <= gn_e[31:0];
                at_machi <= {gn_e[`SLVT_E_KEY], gn_e[47:32]};
              end
            end
          end
        end
        default: at_st <= ST_IDLE;
      endcase
      case (vt_cmd)
        `SLVT_VT_INIT: begin
          vt_ptr <= vt_ptr + 12'h001;
          if (vt_ptr == `SLVT_VT_LAST)
            vt_acc[`SLVT_A_CMD] <= `SLVT_VT_IDLE;
        end
        `SLVT_VT_READ: begin
          vt_acc <= {vt_mem[vt_idx[`SLVT_V_VID]][10:0], `SLVT_VT_IDLE};
          vt_idx[`SLVT_V_FLAGS] <= vt_mem[vt_idx[`SLVT_V_VID]][14:11];
        end
        `SLVT_VT_WRITE: vt_acc[`SLVT_A_CMD] <= `SLVT_VT_IDLE;
        default: ;
      endcase
      res_valid <= fr_valid;
      res_hit <= fr_valid && |d_hit;
      res_ipv6_hit <= fr_valid && |d_hit && de[`SLVT_E_KIND] == `SLVT_KIND_IPV6;
      res_ports <= (|d_hit && de[`SLVT_E_KIND] == `SLVT_KIND_IPV6) ?
                   de[`SLVT_E_V6PORTS] : 11'h000;
      res_group_idx <= de[`SLVT_E_DIDX];
      res_vlan_ports <= {1'b1, ve[10:0]};
      res_ingress_drop <= fr_valid && ve[12] && !fr_member;
      res_mirror <= fr_valid && ve[11];
      res_private <= fr_valid && ve[14];
      res_learn_off <= fr_valid && ve[13];
      res_limit_copy <= over_ev && cpcfg[fr_port];
      res_limit_discard <= over_ev && dccfg[fr_port];
      res_refused <= ref_ev;
    end
  end

  // --------------------------------------------------------------
  // register read
  // --------------------------------------------------------------
  wire [3:0] rp = addr[5:2];
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata <= 32'h00000000;
    end else if (!rd) begin
      rdata <= 32'h00000000;
    end else if (addr[7:6] == 2'h1) begin
      rdata <= (rp <= `SLVT_LAST_PORT) ?
               {14'h0000, dccfg[rp], cpcfg[rp], 3'h0, cnt[rp], 3'h0, lim[rp]} : 32'h00000000;
    end else begin
      case (addr)
        `SLVT_REG_AT_CMD: rdata <= {15'h0000, at_ctl};
        `SLVT_REG_AT_MACLO: rdata <= at_maclo;
        `SLVT_REG_AT_MACHI: rdata <= {3'h0, at_machi};
        `SLVT_REG_AT_INDEX: rdata <= {28'h0000000, at_idx};
        `SLVT_REG_FILTER: rdata <= {12'h000, flt};
        `SLVT_REG_KEYCFG: rdata <= {20'h00000, kmask};
        `SLVT_REG_VT_INDEX: rdata <= {16'h0000, vt_idx};
        `SLVT_REG_VT_CMD: rdata <= {19'h00000, vt_acc};
        `SLVT_REG_REFUSED: rdata <= refused;
        default: rdata <= 32'h00000000;
      endcase
    end
  end
endmodule

// [tb/slvt_assertions.sv]
// Purpose: port-level checks of the lookup tables
// Assumes: one clock, asynchronous active-high reset
// Notes: sees only top-level ports
`timescale 1ns/1ps
module slvt_checker (
  input wire clk,
  input wire rst,
  input wire rd,
  input wire [31:0] rdata,
  input wire fr_valid,
  input wire [3:0] fr_port,
  input wire res_valid,
  input wire res_hit,
  input wire res_ipv6_hit,
  input wire [10:0] res_ports,
  input wire [11:0] res_vlan_ports,
  input wire res_ingress_drop,
  input wire res_mirror,
  input wire res_private,
  input wire res_learn_off,
  input wire res_limit_copy,
  input wire res_limit_discard,
  input wire res_refused
);
  // ------------------------------------------------
  // properties
  // ------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  result_pulse_a: assert property (fr_valid |=> res_valid)
    else $error("lookup result missing");
  cpu_member_a: assert property (res_valid |-> res_vlan_ports[11])
    else $error("cpu port not a member");
  read_quiet_a: assert property (!rd |=> rdata == 32'h0)
    else $error("read data outside read cycle");
  v6_ports_a: assert property (res_valid && !res_ipv6_hit |-> res_ports == 11'h000)
    else $error("ports without ipv6 hit");
  v6_hit_a: assert property (res_ipv6_hit |-> res_hit && res_valid)
    else $error("ipv6 hit without hit");
  // drop only when the ingress port is absent from the mask
  drop_member_a: assert property (fr_valid |=> !(res_ingress_drop && res_vlan_ports[$past(fr_port)]))
    else $error("member port dropped");
  limit_refused_a: assert property (res_limit_copy || res_limit_discard |-> res_refused)
    else $error("limit action without refusal");
  flags_gated_a: assert property (!res_valid |-> !(res_mirror || res_private || res_learn_off))
    else $error("vlan flags without frame");
endmodule

// [tb/tb_top.sv]
// Purpose: directed test of address and vlan lookup tables
// Assumes: register port with one-cycle read latency
// Notes: cpu port 11 used for lookups since it never learns
`timescale 1ns/1ps
module tb_top;
  logic clk, rst, wr, rd, fr_valid, fr_ipv6, fr_key_ext;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, d;
  logic [3:0] fr_port;
  logic [11:0] fr_vid, fr_key_val, res_vlan_ports;
  logic [47:0] fr_dmac, fr_smac;
  logic [1:0] fr_key_sel;
  logic res_valid, res_hit, res_ipv6_hit, res_ingress_drop, res_mirror, res_private;
  logic res_learn_off, res_limit_copy, res_limit_discard, res_refused;
  logic [10:0] res_ports;
  logic [5:0] res_group_idx;
  int failures, tests_run;
  slvt_top slvt_top_i (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .fr_valid(fr_valid), .fr_port(fr_port), .fr_vid(fr_vid),
    .fr_dmac(fr_dmac), .fr_smac(fr_smac), .fr_ipv6(fr_ipv6), .fr_key_sel(fr_key_sel),
    .fr_key_val(fr_key_val), .fr_key_ext(fr_key_ext), .res_valid(res_valid),
    .res_hit(res_hit), .res_ipv6_hit(res_ipv6_hit), .res_ports(res_ports),
    .res_group_idx(res_group_idx), .res_vlan_ports(res_vlan_ports),
    .res_ingress_drop(res_ingress_drop), .res_mirror(res_mirror),
    .res_private(res_private), .res_learn_off(res_learn_off),
    .res_limit_copy(res_limit_copy), .res_limit_discard(res_limit_discard),
    .res_refused(res_refused));
  // ------------------------------------------------
  // tasks
  // ------------------------------------------------
  task automatic end_of_test();
    $display("failures %0d tests_run %0d", failures, tests_run);
    if (failures == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic check(input string n, input logic [47:0] s, e);
    tests_run++;
    if (s !== e) begin
      failures++;
      $display("CHECK FAILED %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  // bounded poll: a hung command ends the run
  task automatic poll(input logic [7:0] a, input logic [31:0] m);
    int n;
    n = 0;
    rreg(a);
    while ((d & m) !== 32'h0 && n < 3000) begin
      rreg(a);
      n++;
    end
    if (n == 3000) begin
      failures++;
      end_of_test();
    end
  endtask
  // x = {ipv6, key select for source, key select for destination}
  task automatic frame(input logic [3:0] p, input logic [11:0] v, kv,
                       input logic [47:0] dm, sm, input logic [2:0] x);
    @(posedge clk);
    fr_valid <= 1'b1;
    fr_port <= p;
    fr_vid <= v;
    fr_key_val <= kv;
    fr_dmac <= dm;
    fr_smac <= sm;
    {fr_ipv6, fr_key_sel} <= x;
    @(posedge clk);
    fr_valid <= 1'b0;
    #1;
  endtask
  // ------------------------------------------------
  // stimulus
  // ------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    {rst, wr, rd, fr_valid, fr_ipv6, fr_key_ext, fr_key_sel} = 8'h80;
    {addr, wdata, fr_port, fr_vid, fr_key_val, fr_dmac, fr_smac} = '0;
    failures = 0;
    tests_run = 0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    poll(8'h1C, 32'h3);
    rreg(8'h14); check("merge mask", d, 48'h0);
    rreg(8'h40); check("limit0", d, 48'h10);
    rreg(8'h20); check("refused", d, 48'h0);
    rreg(8'hFC); check("unmapped", d, 48'h0);
    wreg(8'h18, 32'h5);
    wreg(8'h1C, 32'h2);
    poll(8'h1C, 32'h3);
    rreg(8'h1C); check("vt mask", d, 48'h1FFC);
    rreg(8'h18); check("vt flags", d, 48'h5);
    wreg(8'h18, 32'h2007);
    wreg(8'h1C, 32'hF);
    poll(8'h1C, 32'h3);
    frame(4'h2, 12'h7, 12'h0, 48'h0, 48'h0, 3'h0);
    check("drop", res_ingress_drop, 48'h1);
    check("members", res_vlan_ports, 48'h803);
    frame(4'h1, 12'h7, 12'h0, 48'h0, 48'h0, 3'h0);
    check("no drop", res_ingress_drop, 48'h0);
    frame(4'h0, 12'h7, 12'h0, 48'h0, 48'hA1, 3'h0);
    frame(4'hB, 12'h7, 12'h0, 48'hA1, 48'h0, 3'h0);
    check("hit vid7", res_hit, 48'h1);
    frame(4'hB, 12'h8, 12'h0, 48'hA1, 48'h0, 3'h0);
    check("miss vid8", res_hit, 48'h0);
    wreg(8'h18, 32'h4009);
    wreg(8'h1C, 32'h1FFF);
    poll(8'h1C, 32'h3);
    frame(4'h0, 12'h9, 12'h0, 48'h0, 48'hE1, 3'h0);
    check("learn off", res_learn_off, 48'h1);
    frame(4'hB, 12'h9, 12'h0, 48'hE1, 48'h0, 3'h0);
    check("not learned", res_hit, 48'h0);
    wreg(8'h4C, 32'h10001);
    frame(4'h3, 12'h8, 12'h0, 48'h0, 48'hB1, 3'h0);
    frame(4'h3, 12'h8, 12'h0, 48'h0, 48'hC1, 3'h0);
    check("over limit", res_refused, 48'h1);
    check("copy", res_limit_copy, 48'h1);
    check("discard", res_limit_discard, 48'h0);
    rreg(8'h20); check("refused 1", d, 48'h1);
    rreg(8'h4C); check("count3", d, 48'h10101);
    frame(4'h4, 12'h8, 12'h0, 48'h0, 48'hB1, 3'h0);
    rreg(8'h4C); check("count3 moved", d, 48'h10001);
    rreg(8'h50); check("count4", d, 48'h110);
    wreg(8'h14, 32'hFFF);
    frame(4'h0, 12'h14, 12'h0, 48'h0, 48'hD1, 3'h0);
    frame(4'hB, 12'h1E, 12'h0, 48'hD1, 48'h0, 3'h0);
    check("shared hit", res_hit, 48'h1);
    frame(4'hB, 12'h1E, 12'h123, 48'hD1, 48'h0, 3'h1);
    check("override miss", res_hit, 48'h0);
    frame(4'hB, 12'h1E, 12'h0, 48'hD1, 48'h0, 3'h1);
    check("override hit", res_hit, 48'h1);
    frame(4'h1, 12'h28, 12'h55, 48'h0, 48'hF1, 3'h2);
    frame(4'hB, 12'h29, 12'h55, 48'hF1, 48'h0, 3'h1);
    check("learned key", res_hit, 48'h1);
    wreg(8'h14, 32'h0);
    wreg(8'h04, 32'h00112233);
    wreg(8'h08, 32'h000C0308);
    wreg(8'h00, 32'h59);
    poll(8'h00, 32'h7);
    frame(4'hB, 12'hC, 12'h0, 48'h333300112233, 48'h0, 3'h4);
    check("v6 hit", res_ipv6_hit, 48'h1);
    check("v6 ports", res_ports, 48'h308);
    frame(4'hB, 12'hC, 12'h0, 48'h333300112233, 48'h0, 3'h0);
    check("not v6 frame", res_ipv6_hit, 48'h0);
    frame(4'hB, 12'hD, 12'h0, 48'h333300112233, 48'h0, 3'h4);
    check("other vid", res_hit, 48'h0);
    wreg(8'h04, 32'hD1);
    wreg(8'h08, 32'h0);
    wreg(8'h00, 32'h7);
    poll(8'h00, 32'h7);
    check("next found", d[6], 48'h1);
    rreg(8'h04); check("next mac", d, 48'h0);
    rreg(8'h08); check("next key", d, 48'h70000);
    wreg(8'h10, 32'h14);
    wreg(8'h04, 32'hD1);
    wreg(8'h08, 32'h0);
    wreg(8'h00, 32'h7);
    poll(8'h00, 32'h7);
    rreg(8'h04); check("filtered next", d, 48'hB1);
    wreg(8'h10, 32'h200F4);
    wreg(8'h04, 32'hD1);
    wreg(8'h08, 32'h0);
    wreg(8'h00, 32'h7);
    poll(8'h00, 32'h7);
    check("both filters", d[6], 48'h0);
    wreg(8'h10, 32'h0);
    wreg(8'h04, 32'hB1);
    wreg(8'h08, 32'h80000);
    wreg(8'h00, 32'h2);
    poll(8'h00, 32'h7);
    rreg(8'h50); check("forget count", d, 48'h10);
    wreg(8'h10, 32'h11);
    wreg(8'h00, 32'h3);
    poll(8'h00, 32'h7);
    wreg(8'h00, 32'h3);
    poll(8'h00, 32'h7);
    rreg(8'h44); check("aged port1", d, 48'h10);
    rreg(8'h40); check("kept port0", d, 48'h210);
    wreg(8'h1C, 32'h1);
    poll(8'h1C, 32'h3);
    wreg(8'h18, 32'h7);
    wreg(8'h1C, 32'h2);
    poll(8'h1C, 32'h3);
    check("init mask", d, 48'h1FFC);
    rreg(8'h18); check("init flags", d, 48'h7);
    end_of_test();
  end
endmodule
bind slvt_top slvt_checker slvt_checker_i (.clk(clk), .rst(rst), .rd(rd), .rdata(rdata),
  .fr_valid(fr_valid), .fr_port(fr_port), .res_valid(res_valid), .res_hit(res_hit),
  .res_ipv6_hit(res_ipv6_hit), .res_ports(res_ports), .res_vlan_ports(res_vlan_ports),
  .res_ingress_drop(res_ingress_drop), .res_mirror(res_mirror), .res_private(res_private),
  .res_learn_off(res_learn_off), .res_limit_copy(res_limit_copy),
  .res_limit_discard(res_limit_discard), .res_refused(res_refused));
